// ===== rtl/spm_defs.vh
// Constants of the serial port engine for modes zero and one
`ifndef SPM_DEFS_VH
`define SPM_DEFS_VH

// ==========================================================
// Register map (byte addresses, one word each)
`define SPM_ADR_BUFFER 4'h0
`define SPM_ADR_CONTROL 4'h4
`define SPM_ADR_STATUS 4'h8

// ==========================================================
// Control and status register fields
`define SPM_CTL_MODE 0
`define SPM_CTL_RXALLOW 1
`define SPM_CTL_MPFILTER 2
`define SPM_CTL_TXDONE 3
`define SPM_CTL_RXDONE 4
`define SPM_CTL_NINTH 5
`define SPM_STA_TXBUSY 0
`define SPM_STA_RXBUSY 1

// ==========================================================
// Machine cycle phases: index = (state - 1) * 2 + (phase - 1)
`define SPM_PH_LAST 4'hb
`define SPM_PH_S1P1 4'h0
`define SPM_PH_S3P1 4'h4
`define SPM_PH_S5P2 4'h9
`define SPM_PH_S6P1 4'ha
`define SPM_PH_S6P2 4'hb

// ==========================================================
// Shift register preloads and markers, divider last state and vote counter states
`define SPM_TX_LOAD_MARK 1'h1
`define SPM_TX_END_PATTERN 8'h01
`define SPM_RX0_PRELOAD 8'hfe
`define SPM_RX1_PRELOAD 9'h1ff
`define SPM_DIV_LAST 4'hf
`define SPM_VOTE_A 4'h6
`define SPM_VOTE_B 4'h7
`define SPM_VOTE_C 4'h8

`endif

// ===== rtl/spm_serial_port.v
// Serial port engine: synchronous shift mode and asynchronous 10-bit mode
//
// Our own choices: the register addresses and the Wishbone register port.
`include "spm_defs.vh"

// Behaviour
// R1: Sync mode moves 8 bits LSB first on data pin, drives clock pin.
// R2: Sync bit rate is one twelfth of the CPU clock, fixed; here one bit per twelve clk ticks.
// R3: Buffer write loads ninth-position one; sending starts one cycle later.
// R4: Sync send drives shift output; clock low S3-S5, high S6-S2.
// R5: Each S6P2 while sending, transmit register shifts right, zero fill.
// R6: Marker beside MSB: last shift, end send, done flag at 10th cycle.
// R7: Sync receive starts when allowed and done flag clear; preload 11111110.
// R8: Sync receive drives shift clock with edges at S3P1 and S6P1.
// R9: Each S6P2 receive register shifts left, taking the S5P2 sample.
// R10: Zero reaches left end: last shift, load buffer, set done flag.
// R11: Async frame is start, 8 data LSB first, stop; stop kept.
// R12: Async bit timing comes from timer one overflow rate.
// R13: Async transmit starts after the next divide-by-16 rollover.
// R14: Start bit, then shift output one bit later, first shift after.
// R15: Async transmit ends and sets done at the 10th rollover.
// R16: Input sampled at 16x; falling edge resets counter, preloads 1FFH.
// R17: Each bit is majority of samples at counter states 7, 8, 9.
// R18: Nonzero first bit resets receiver, watching for falling edge again.
// R19: Nine-bit receive register; start at left end triggers final shift.
// R20: Store only if done flag clear and filter off or stop one.
// R21: After every async frame, return to watching for falling edge.
// R22: Async reception begins only while receive is allowed.
// R23: Done flags stay set until cleared; interrupt requested while set.
module spm_serial_port (
  input wire clk, // 200 MHz clock, one tick per clock phase
  input wire reset, // Synchronous reset, active high
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write enable
  input wire [3:0] wb_adr_i, // Wishbone byte address
  input wire [3:0] wb_sel_i, // Wishbone byte selects
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  input wire timerOverflow, // Timer one overflow pulse, same clock
  output reg portOneBitZeroOut, // Shift clock or async transmit line
  input wire portOneBitOneIn, // Data pin level
  output reg portOneBitOneOut, // Data pin drive value
  output reg portOneBitOneOe, // Data pin drive enable
  output reg serialIrq // Serial port interrupt request
);

  // ========================================================
  // Transmit states
  localparam TX_IDLE = 3'h0;
  localparam TX_ALIGN = 3'h1;
  localparam TX_ARM = 3'h2;
  localparam TX_SEND = 3'h3;
  localparam TX_END = 3'h4;
  localparam TX_AWAIT = 3'h5;
  localparam TX_ASTART = 3'h6;
  localparam TX_ADATA = 3'h7;
  // Receive states
  localparam RX_IDLE = 3'h0;
  localparam RX_LOAD = 3'h1;
  localparam RX_SHIFT = 3'h2;
  localparam RX_END = 3'h3;
  localparam RX_AHUNT = 3'h4;
  localparam RX_ABIT = 3'h5;
  localparam RX_ALIGN = 3'h6;

  // ========================================================
  // Registers
  reg [3:0] phase_ff;
  reg [2:0] txState_ff;
  reg [2:0] rxState_ff;
  reg [8:0] txShift_ff;
  reg [8:0] rxShift_ff;
  reg [3:0] txDiv_ff;
  reg [3:0] rxDiv_ff;
  reg [2:0] votes_ff;
  reg pinMeta_ff;
  reg pinSync_ff;
  reg pinPrev_ff;
  reg sample_ff;
  reg [7:0] buffer_ff;
  reg mode_ff;
  reg rxAllow_ff;
  reg mpFilter_ff;
  reg txDone_ff;
  reg rxDone_ff;
  reg ninth_ff;

  // ========================================================
  // Bus decode: a write takes effect on the edge that sees ack high
  wire busReq = wb_cyc_i & wb_stb_i;
  wire busWrite = busReq & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire wrBuffer = busWrite & (wb_adr_i == `SPM_ADR_BUFFER);
  wire wrControl = busWrite & (wb_adr_i == `SPM_ADR_CONTROL);
  wire txBusy = (txState_ff != TX_IDLE);
  wire rxBusy = (rxState_ff != RX_IDLE) & (rxState_ff != RX_AHUNT);

  // ========================================================
  // Timing strobes
  wire atS6P2 = (phase_ff == `SPM_PH_S6P2);
  wire atS1P1 = (phase_ff == `SPM_PH_S1P1);
  wire atS5P2 = (phase_ff == `SPM_PH_S5P2);
  // R12: bit timing from timer overflow
  wire txRoll = timerOverflow & (txDiv_ff == `SPM_DIV_LAST);
  wire rxRoll = timerOverflow & (rxDiv_ff == `SPM_DIV_LAST);
  // R2: shift clock low S3P1..S5P2, twelve phases per bit
  wire clkLow = (phase_ff >= `SPM_PH_S3P1) & (phase_ff < `SPM_PH_S6P1);

  // ========================================================
  // Majority vote and bit-order reversal
  // R17: two of three samples decide
  wire voteBit = (votes_ff[0] & votes_ff[1]) | (votes_ff[0] & votes_ff[2]) |
    (votes_ff[1] & votes_ff[2]);
  wire [7:0] rx0Shifted = {rxShift_ff[6:0], sample_ff};
  wire [7:0] revSrc = mode_ff ? rxShift_ff[7:0] : rx0Shifted;
  wire [7:0] revData;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_rev
      assign revData[gi] = revSrc[7 - gi];
    end
  endgenerate

  // ========================================================
  // Phase counter and pin synchroniser
  always @(posedge clk) begin
    if (reset) begin
      phase_ff <= 4'h0;
      pinMeta_ff <= 1'h1;
      pinSync_ff <= 1'h1;
    end else begin
      phase_ff <= (phase_ff == `SPM_PH_LAST) ? 4'h0 : phase_ff + 4'h1;
      pinMeta_ff <= portOneBitOneIn;
      pinSync_ff <= pinMeta_ff;
    end
  end

  // ========================================================
  // Control register and flags; hardware set wins over clear
  always @(posedge clk) begin
    if (reset) begin
      mode_ff <= 1'h0;
      rxAllow_ff <= 1'h0;
      mpFilter_ff <= 1'h0;
      txDone_ff <= 1'h0;
      rxDone_ff <= 1'h0;
    end else begin
      if (wrControl) begin
        mode_ff <= wb_dat_i[`SPM_CTL_MODE];
        rxAllow_ff <= wb_dat_i[`SPM_CTL_RXALLOW];
        mpFilter_ff <= wb_dat_i[`SPM_CTL_MPFILTER];
      end
      // R23: flags held until software writes zero
      if ((txState_ff == TX_END && atS1P1) ||
          (txState_ff == TX_ADATA && txRoll &&
           txShift_ff[8:1] == `SPM_TX_END_PATTERN))
        txDone_ff <= 1'h1;
      else if (wrControl)
        txDone_ff <= wb_dat_i[`SPM_CTL_TXDONE];
      if ((rxState_ff == RX_END && atS1P1) ||
          (rxState_ff == RX_ABIT && rxRoll && !rxShift_ff[8] &&
           !rxDone_ff && (!mpFilter_ff || voteBit)))
        rxDone_ff <= 1'h1;
      else if (wrControl)
        rxDone_ff <= wb_dat_i[`SPM_CTL_RXDONE];
    end
  end

  // ========================================================
  // Transmit engine
  always @(posedge clk) begin
    if (reset) begin
      txState_ff <= TX_IDLE;
      txShift_ff <= 9'h000;
      txDiv_ff <= 4'h0;
    end else begin
      if (timerOverflow)
        txDiv_ff <= txDiv_ff + 4'h1;
      case (txState_ff)
        TX_IDLE: begin
          // R3: marker one in ninth position on buffer write
          if (wrBuffer) begin
            txShift_ff <= {`SPM_TX_LOAD_MARK, wb_dat_i[7:0]};
            txState_ff <= mode_ff ? TX_AWAIT : TX_ALIGN;
          end
        end
        TX_ALIGN: begin
          if (atS6P2)
            txState_ff <= TX_ARM;
        end
        TX_ARM: begin
          // R3: send begins one machine cycle after the write
          if (atS6P2)
            txState_ff <= TX_SEND;
        end
        TX_SEND: begin
          // R5: shift right with zero fill at S6P2
          if (atS6P2) begin
            txShift_ff <= {1'h0, txShift_ff[8:1]};
            // R6: marker beside MSB, this is the last shift
            if (txShift_ff[8:1] == `SPM_TX_END_PATTERN)
              txState_ff <= TX_END;
          end
        end
        TX_END: begin
          // R6: send ends at S1P1 of the tenth cycle
          if (atS1P1)
            txState_ff <= TX_IDLE;
        end
        TX_AWAIT: begin
          // R13: bit times follow the divide-by-16 counter
          if (txRoll)
            txState_ff <= TX_ASTART;
        end
        TX_ASTART: begin
          // R14: start bit lasts one bit time
          if (txRoll)
            txState_ff <= TX_ADATA;
        end
        TX_ADATA: begin
          // R14: first shift one bit time after data drive
          if (txRoll) begin
            txShift_ff <= {1'h0, txShift_ff[8:1]};
            // R15: last shift at the tenth rollover
            if (txShift_ff[8:1] == `SPM_TX_END_PATTERN)
              txState_ff <= TX_IDLE;
          end
        end
        default: txState_ff <= TX_IDLE;
      endcase
    end
  end

  // ========================================================
  // Receive engine
  always @(posedge clk) begin
    if (reset) begin
      rxState_ff <= RX_IDLE;
      rxShift_ff <= 9'h000;
      rxDiv_ff <= 4'h0;
      votes_ff <= 3'h0;
      pinPrev_ff <= 1'h1;
      sample_ff <= 1'h1;
      buffer_ff <= 8'h00;
      ninth_ff <= 1'h0;
    end else begin
      // R9: data pin sampled at S5P2
      if (atS5P2)
        sample_ff <= pinSync_ff;
      // R16: line sampled at sixteen times the bit rate
      if (timerOverflow)
        pinPrev_ff <= pinSync_ff;
      if (timerOverflow)
        rxDiv_ff <= rxDiv_ff + 4'h1;
      // R17: votes taken at counter states seven to nine
      if (timerOverflow && rxDiv_ff == `SPM_VOTE_A)
        votes_ff[0] <= pinSync_ff;
      if (timerOverflow && rxDiv_ff == `SPM_VOTE_B)
        votes_ff[1] <= pinSync_ff;
      if (timerOverflow && rxDiv_ff == `SPM_VOTE_C)
        votes_ff[2] <= pinSync_ff;
      case (rxState_ff)
        RX_IDLE: begin
          // R7: sync receive starts when allowed and flag clear
          // R7: condition counts from its S6P2, as a buffer write does
          if (!mode_ff && rxAllow_ff && !rxDone_ff && !txBusy)
            rxState_ff <= atS6P2 ? RX_LOAD : RX_ALIGN;
          // R22: async hunting only while receive allowed
          else if (mode_ff && rxAllow_ff)
            rxState_ff <= RX_AHUNT;
        end
        RX_ALIGN: begin
          // R10: align first so the flag lands in the tenth cycle
          if (atS6P2)
            rxState_ff <= RX_LOAD;
        end
        RX_LOAD: begin
          // R7: preload, receive active one phase later
          if (atS6P2) begin
            rxShift_ff <= {1'h0, `SPM_RX0_PRELOAD};
            rxState_ff <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          // R9: shift left taking the S5P2 sample
          if (atS6P2) begin
            rxShift_ff <= {1'h0, rx0Shifted};
            // R10: zero at left end, last shift loads buffer
            if (!rxShift_ff[7]) begin
              buffer_ff <= revData;
              rxState_ff <= RX_END;
            end
          end
        end
        RX_END: begin
          // R10: receive cleared at S1P1 as flag is set
          if (atS1P1)
            rxState_ff <= RX_IDLE;
        end
        RX_AHUNT: begin
          if (!mode_ff || !rxAllow_ff)
            rxState_ff <= RX_IDLE;
          // R16: falling edge resets counter and preloads
          else if (timerOverflow && pinPrev_ff && !pinSync_ff) begin
            rxDiv_ff <= 4'h0;
            rxShift_ff <= `SPM_RX1_PRELOAD;
            rxState_ff <= RX_ABIT;
          end
        end
        RX_ABIT: begin
          if (!mode_ff)
            rxState_ff <= RX_IDLE;
          else if (rxRoll) begin
            rxShift_ff <= {rxShift_ff[7:0], voteBit};
            // R18: false start bit sends receiver back to hunting
            if (rxShift_ff == `SPM_RX1_PRELOAD && voteBit)
              rxState_ff <= RX_AHUNT;
            // R19: start bit at left end, this is the final shift
            else if (!rxShift_ff[8]) begin
              // R20: store only with flag clear and filter passed
              // R11: stop bit kept as ninth bit
              if (!rxDone_ff && (!mpFilter_ff || voteBit)) begin
                buffer_ff <= revData;
                ninth_ff <= voteBit;
              end
              // R21: back to watching for a falling edge
              rxState_ff <= RX_AHUNT;
            end
          end
        end
        default: rxState_ff <= RX_IDLE;
      endcase
    end
  end

  // ========================================================
  // Pins, interrupt and bus answer; all registered
  always @(posedge clk) begin
    if (reset) begin
      portOneBitZeroOut <= 1'h1;
      portOneBitOneOut <= 1'h1;
      portOneBitOneOe <= 1'h0;
      serialIrq <= 1'h0;
      wb_ack_o <= 1'h0;
      wb_dat_o <= 32'h00000000;
    end else begin
      if (mode_ff) begin
        // R11: idle high, start zero, then data LSB first
        portOneBitZeroOut <= (txState_ff == TX_ASTART) ? 1'h0 :
          (txState_ff == TX_ADATA) ? txShift_ff[0] : 1'h1;
        portOneBitOneOut <= 1'h1;
        portOneBitOneOe <= 1'h0;
      end else begin
        // R4: shift clock only during send or receive
        // R8: clock edges at S3P1 and S6P1 while receiving
        portOneBitZeroOut <= ~(clkLow && (txState_ff == TX_SEND ||
          rxState_ff == RX_SHIFT));
        // R1: data pin driven only while sending
        portOneBitOneOut <= (txState_ff == TX_SEND) ? txShift_ff[0] : 1'h1;
        portOneBitOneOe <= (txState_ff == TX_SEND);
      end
      // R23: interrupt requested while a flag stands
      serialIrq <= txDone_ff | rxDone_ff;
      wb_ack_o <= busReq & ~wb_ack_o;
      wb_dat_o <= 32'h00000000;
      if (busReq && !wb_ack_o && !wb_we_i) begin
        case (wb_adr_i)
          `SPM_ADR_BUFFER: wb_dat_o[7:0] <= buffer_ff;
          `SPM_ADR_CONTROL: wb_dat_o[5:0] <= {ninth_ff, rxDone_ff,
            txDone_ff, mpFilter_ff, rxAllow_ff, mode_ff};
          `SPM_ADR_STATUS: wb_dat_o[1:0] <= {rxBusy, txBusy};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ===== tb/spm_serial_port_sva.sv
// Assertions on the serial port engine ports
`include "spm_defs.vh"
module spm_serial_port_sva (
  input wire clk, // Clock
  input wire reset, // Sync reset
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Strobe
  input wire wb_we_i, // Write enable
  input wire [3:0] wb_adr_i, // Address
  input wire [3:0] wb_sel_i, // Byte selects
  input wire [31:0] wb_dat_i, // Write data
  input wire [31:0] wb_dat_o, // Read data
  input wire wb_ack_o, // Acknowledge
  input wire timerOverflow, // Bit rate tick
  input wire portOneBitZeroOut, // Shift clock or tx line
  input wire portOneBitOneOut, // Data drive value
  input wire portOneBitOneOe, // Data drive enable
  input wire serialIrq // Interrupt request
);
  logic modeFf;
  logic [7:0] oeCntFf;
  wire ctlWr = wb_ack_o && wb_we_i && wb_sel_i[0] &&
    wb_adr_i == `SPM_ADR_CONTROL;
  // ==========================================================
  // Mode is not visible at the pins, so mirror control writes
  always @(posedge clk) begin
    if (reset) modeFf <= 1'b0;
    else if (ctlWr) modeFf <= wb_dat_i[`SPM_CTL_MODE];
  end
  always @(posedge clk) begin
    if (reset || !portOneBitOneOe) oeCntFf <= 8'h0;
    else oeCntFf <= oeCntFf + 8'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // Properties
  ack_one_shot_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  rdat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  sck_low_six_a: assert property (
    !modeFf && $fell(portOneBitZeroOut) |=>
    !portOneBitZeroOut [*5] ##1 portOneBitZeroOut)
    else $error("shift clock low phase not six clocks");
  data_steady_a: assert property (
    portOneBitOneOe && $changed(portOneBitOneOut) |-> portOneBitZeroOut)
    else $error("data changed while shift clock low");
  send_len_a: assert property (
    $fell(portOneBitOneOe) |-> oeCntFf >= 8'd96 && oeCntFf <= 8'd98)
    else $error("send phase length wrong");
  oe_sync_only_a: assert property (portOneBitOneOe |-> !modeFf)
    else $error("data pin driven in async mode");
  irq_hold_a: assert property (
    $fell(serialIrq) |-> $past(ctlWr, 1) || $past(ctlWr, 2))
    else $error("interrupt dropped without control write");
  tx_on_tick_a: assert property (
    modeFf && !portOneBitOneOe && $changed(portOneBitZeroOut) |->
    $past(timerOverflow, 1) || $past(timerOverflow, 2))
    else $error("async line moved off the bit grid");
  cover property ($rose(portOneBitOneOe));
  cover property ($rose(serialIrq));
  cover property (modeFf && $fell(portOneBitZeroOut));
endmodule

// ===== tb/spm_link_partner.sv
// Far side model: shift register for mode 0, remote sender for mode 1
module spm_link_partner (
  input wire clk, // Clock
  input wire modeAsync, // Async mode selected
  input wire tick, // 16x bit tick
  input wire shiftClk, // Device shift clock
  input wire devOut, // Device data value
  input wire devOe, // Device data enable
  input wire load, // Load shift register
  input wire [7:0] loadByte, // Byte to load
  input wire frameGo, // Start async frame
  input wire [9:0] frameBits, // Frame, start bit first
  output logic [7:0] shFf, // Shift register
  output wire line // Data pin level
);
  logic prevClkFf = 1'b1;
  logic [9:0] frmFf = 10'h3ff;
  logic [3:0] tcFf = 4'h0;
  logic [3:0] leftFf = 4'h0;
  always @(posedge clk) begin
    prevClkFf <= shiftClk;
    // LSB first, taken on rising clock
    if (load) shFf <= loadByte;
    else if (!modeAsync && shiftClk && !prevClkFf) shFf <= {line, shFf[7:1]};
    if (frameGo) begin
      frmFf <= frameBits;
      leftFf <= 4'ha;
      tcFf <= 4'h0;
    end else if (tick && leftFf != 4'h0) begin
      tcFf <= tcFf + 4'h1;
      if (tcFf == 4'hf) begin
        frmFf <= {1'b1, frmFf[9:1]};
        leftFf <= leftFf - 4'h1;
      end
    end
  end
  // Idle async line rests high
  assign line = modeAsync ? (leftFf != 4'h0 ? frmFf[0] : 1'b1) :
    (devOe ? devOut : shFf[0]);
endmodule

// ===== tb/serial_port_modes_zero_one_tb_top.sv
// Testbench of the serial port engine
`include "spm_defs.vh"
module serial_port_modes_zero_one_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, tick = 0;
  logic ld = 1, go = 0, modeA = 0;
  logic [1:0] tc = 2'h0;
  logic [3:0] adr = 4'h0;
  logic [7:0] ldB = 8'h0;
  logic [9:0] frm = 10'h3ff;
  logic [31:0] dat = 32'h0, q;
  wire ack, sck, din, dout, doe, irq;
  wire [7:0] psh;
  wire [31:0] rdat;
  int miscompares = 0, n_checks = 0;
  spm_serial_port spm_serial_port_i (.clk(clk), .reset(reset),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timerOverflow(tick), .portOneBitZeroOut(sck), .portOneBitOneIn(din),
    .portOneBitOneOut(dout), .portOneBitOneOe(doe), .serialIrq(irq));
  spm_link_partner spm_link_partner_i (.clk(clk), .modeAsync(modeA),
    .tick(tick), .shiftClk(sck), .devOut(dout), .devOe(doe), .load(ld),
    .loadByte(ldB), .frameGo(go), .frameBits(frm), .shFf(psh), .line(din));
  initial forever #2.5 clk = ~clk;
  // Overflow tick every 4 clocks: one bit is 64 clocks
  always @(posedge clk) begin
    tc <= tc + 2'h1;
    tick <= (tc == 2'h3);
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task finish_test;
    if (miscompares == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    // No cycle limit here: only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 0; stb <= 0;
    @(posedge clk);
  endtask
  task waitIrq(output int n);
    @(posedge clk);
    for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
  endtask
  function logic win(int n);
    return n >= 100 && n <= 125;
  endfunction
  function logic stores(logic pre, logic f, logic s, logic al);
    return al && !pre && (!f || s);
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test;
  end
  initial begin
    int n, i;
    logic [7:0] b, last;
    logic [9:0] fb;
    logic nin, st, f, s, al, pre;
    void'($urandom(25543));
    repeat (4) @(posedge clk);
    reset <= 0; ld <= 0;
    @(posedge clk);
    // ==========================================================
    // Reset state, unmapped place, sync send
    wb(0, `SPM_ADR_CONTROL, 32'h0); chk(q, 32'h0, "ctl");
    wb(0, 4'hc, 32'h0); chk(q, 32'h0, "unmapped");
    b = $urandom;
    wb(1, `SPM_ADR_BUFFER, {24'h0, b}); waitIrq(n);
    chk(win(n), 1, "txtime");
    chk(psh, b, "txbyte");
    wb(0, `SPM_ADR_CONTROL, 32'h0); chk(q[4:0], 5'h08, "txflag");
    // ==========================================================
    // Sync receive; the write also clears the send flag
    b = $urandom; ld <= 1; ldB <= b; @(posedge clk); ld <= 0;
    wb(1, `SPM_ADR_CONTROL, 32'h2); waitIrq(n);
    chk(win(n), 1, "rxtime");
    wb(0, `SPM_ADR_CONTROL, 32'h0); chk(q[4:0], 5'h12, "rxflag");
    wb(1, `SPM_ADR_CONTROL, 32'h0);
    wb(0, `SPM_ADR_BUFFER, 32'h0); chk(q, {24'h0, b}, "rxbyte");
    last = b;
    // ==========================================================
    // Async send, line sampled mid bit
    modeA <= 1; wb(1, `SPM_ADR_CONTROL, 32'h1);
    b = $urandom; fb = {1'b1, b, 1'b0};
    wb(1, `SPM_ADR_BUFFER, {24'h0, b});
    wb(0, `SPM_ADR_STATUS, 32'h0);
    chk(q, 32'h1, "txbusy");
    for (n = 0; n < 3000 && sck !== 1'b0; n++) @(posedge clk);
    repeat (32) @(posedge clk);
    for (i = 0; i < 10; i++) begin
      chk(sck, fb[i], "txline");
      repeat (64) @(posedge clk);
    end
    wb(0, `SPM_ADR_CONTROL, 32'h0); chk(q[4:0], 5'h09, "atxflag");
    // ==========================================================
    // Async frames: stored, filtered, flag busy, receive off
    for (i = 0; i < 6; i++) begin
      f = i[0]; s = i[1] || i > 3; pre = i == 4; al = i != 5;
      b = $urandom;
      wb(1, `SPM_ADR_CONTROL, {27'h0, pre, 1'b0, f, al, 1'b1});
      frm <= {s, b, 1'b0}; go <= 1; @(posedge clk); go <= 0;
      repeat (320) @(posedge clk);
      wb(0, `SPM_ADR_STATUS, 32'h0);
      chk(q, {30'h0, al, 1'b0}, "rxbusy");
      repeat (400) @(posedge clk);
      st = stores(pre, f, s, al);
      if (st) begin
        last = b;
        nin = s;
      end
      wb(0, `SPM_ADR_CONTROL, 32'h0);
      chk(q, {26'h0, nin, st || pre, 1'b0, f, al, 1'b1}, "rxctl");
      wb(0, `SPM_ADR_BUFFER, 32'h0); chk(q, {24'h0, last}, "rxbuf");
      wb(1, `SPM_ADR_CONTROL, 32'h1);
    end
    finish_test;
  end
endmodule
bind spm_serial_port spm_serial_port_sva spm_serial_port_sva_i (.clk,
  .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .timerOverflow, .portOneBitZeroOut,
  .portOneBitOneOut, .portOneBitOneOe, .serialIrq);
